// ===== sosc_pkg.sv
// Package for the standby and output-state controller: register indices,
// field layouts, reset values and timing figures.
// Assumes a 200 MHz APB clock and 32-bit APB data.
package sosc_pkg;

  // Register indices; the byte address on APB is four times the index.
  localparam logic [7:0] SOSC_IDX_POWER = 8'h00;
  localparam logic [7:0] SOSC_IDX_OUTCTL = 8'h11;
  localparam logic [7:0] SOSC_IDX_SYNCIDLE = 8'h12;
  localparam logic [7:0] SOSC_IDX_CORERUN = 8'h14;
  localparam logic [7:0] SOSC_IDX_OSCEN = 8'h15;
  localparam logic [7:0] SOSC_IDX_POL12 = 8'h25;
  localparam logic [7:0] SOSC_IDX_POL3 = 8'h26;
  localparam logic [7:0] SOSC_IDX_GPOPOL = 8'h27;
  localparam logic [7:0] SOSC_IDX_STATUS = 8'h30;
  localparam logic [7:0] SOSC_IDX_GPODIR = 8'h78;

  // Field positions.
  localparam int SOSC_POWER_LSB = 0;
  localparam int SOSC_CLAMP_BIT = 2;
  localparam int SOSC_SUB_BIT = 24;

  // Reset values.
  localparam logic [1:0] SOSC_RST_POWER = 2'h3;
  localparam logic SOSC_RST_CLAMP = 1'b0;
  localparam logic SOSC_RST_OUTCTL = 1'b0;
  localparam logic SOSC_RST_CORERUN = 1'b0;
  localparam logic SOSC_RST_OSCEN = 1'b0;
  localparam logic [1:0] SOSC_RST_SYNCIDLE = 2'h0;
  localparam logic [24:0] SOSC_RST_POL = 25'h000_0000;
  localparam logic [7:0] SOSC_RST_GPOPOL = 8'h00;
  localparam logic [7:0] SOSC_RST_GPODIR = 8'h00;

  // Oscillator settling time after leaving the deepest standby.
  localparam int SOSC_SETTLE_US = 500;
  localparam int SOSC_CLK_MHZ = 200;
  localparam int SOSC_SETTLE_CYC = SOSC_SETTLE_US * SOSC_CLK_MHZ;

  // Power states in field order: 0 normal, 1..3 standby levels.
  typedef enum logic [1:0] {
    SOSC_NORMAL,
    SOSC_STANDBY1,
    SOSC_STANDBY2,
    SOSC_DEEPEST_STANDBY
  } sosc_power_t;

endpackage

// ===== sosc_standby_output_state_ctrl.sv
// Standby and output-state controller with an APB register slave.
// Run-time levels from the timing core arrive on pclk and are not resynchronised.
`timescale 1ns/100ps

// Function
// - two-bit power field selects power state
// - output-enable low beats standby 1 at the sync outputs only
// - deepest standby stops the crystal oscillator
// - deepest standby drives its own vertical polarities
// - shared polarities for standby 1, 2, disable
// - general outputs idle levels are programmable
// - general pins tristate until direction selects output
// - standby 1, 2 select minimum drive
// - idle polarities default low everywhere except the even horizontal clock, fixed high in standby 1, 2, disable
module sosc_standby_output_state_ctrl
  import sosc_pkg::*;
#(
  parameter int SETTLE_CYC = SOSC_SETTLE_CYC,
  parameter int N_VERT = 24,
  parameter int N_GPO = 8,
  parameter int PADDR_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N_VERT-1:0] vertical_run,
  input wire logic substrate_run,
  input wire logic [N_GPO-1:0] general_run,
  input wire logic horizontal_odd_run,
  input wire logic horizontal_even_run,
  input wire logic last_horizontal_run,
  input wire logic reset_gate_run,
  input wire logic vertical_sync_run,
  input wire logic horizontal_sync_run,
  input wire logic pixel_clock_run,
  input wire logic oscillator_run,
  output logic [N_VERT-1:0] vertical_outs,
  output logic substrate_clock_out,
  output logic [N_GPO-1:0] general_outs,
  output logic [N_GPO-1:0] general_outs_oe,
  output logic horizontal_clock_odd,
  output logic horizontal_clock_even,
  output logic last_horizontal_clock,
  output logic reset_gate_out,
  output logic horizontal_oe,
  output logic drive_minimum,
  output logic vertical_sync,
  output logic horizontal_sync,
  output logic pixel_clock_out,
  output logic crystal_drive_out,
  output logic oscillator_enable,
  output logic analog_front_end_on,
  output logic reference_on,
  output logic clamp_enable,
  output logic timing_core_enable
);

  localparam int CNT_W = $clog2(SETTLE_CYC + 1);

  typedef struct packed {
    logic [1:0] power;
    logic clamp_en;
    logic output_enable_ctrl;
    logic timing_core_run;
    logic osc_en;
    logic [1:0] sync_idle_level;
    logic [24:0] pol12;
    logic [24:0] pol3;
    logic [N_GPO-1:0] gpo_pol;
    logic [N_GPO-1:0] gpo_dir;
    logic [CNT_W-1:0] settle_cnt;
    logic settled;
    logic [31:0] rdata;
    logic slverr;
    logic [N_VERT-1:0] vout;
    logic sub_out;
    logic [N_GPO-1:0] gout;
    logic [N_GPO-1:0] goe;
    logic h_odd;
    logic h_even;
    logic h_last;
    logic rg;
    logic h_oe;
    logic drv_min;
    logic vsync;
    logic hsync;
    logic pix_clk;
    logic xtal;
    logic osc_on;
    logic afe_on;
    logic ref_on;
    logic core_en;
  } sosc_state_t;

  sosc_state_t state_reg;
  sosc_state_t state_next;

  logic [7:0] idx;
  logic mapped;
  logic aligned;
  logic wr_go;
  logic [31:0] rd_val;
  sosc_power_t pstate;
  logic deepest;
  logic idle12;
  logic low_clk;

  assign idx = paddr[9:2];
  // Only whole-word accesses are decoded. Address bits above the index are not
  // looked at, so on a wider bus the map repeats instead of faulting.
  // Keeping the decode to the index keeps the compare narrow; paddr[9:2] needs PADDR_W of at least 10.
  assign aligned = (paddr[1:0] == 2'h0);
  assign pstate = sosc_power_t'(state_reg.power);
  // Zero-wait slave: every access completes in its first access cycle.
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (idx)
      SOSC_IDX_POWER: rd_val[2:0] = {state_reg.clamp_en, state_reg.power};
      SOSC_IDX_OUTCTL: rd_val[0] = state_reg.output_enable_ctrl;
      SOSC_IDX_SYNCIDLE: rd_val[1:0] = state_reg.sync_idle_level;
      SOSC_IDX_CORERUN: rd_val[0] = state_reg.timing_core_run;
      SOSC_IDX_OSCEN: rd_val[0] = state_reg.osc_en;
      SOSC_IDX_POL12: rd_val[24:0] = state_reg.pol12;
      SOSC_IDX_POL3: rd_val[24:0] = state_reg.pol3;
      SOSC_IDX_GPOPOL: rd_val[N_GPO-1:0] = state_reg.gpo_pol;
      SOSC_IDX_GPODIR: rd_val[N_GPO-1:0] = state_reg.gpo_dir;
      SOSC_IDX_STATUS: rd_val[7:0] = {1'b0, ~idle12 & ~deepest, state_reg.settled,
        state_reg.afe_on, state_reg.osc_on, state_reg.core_en, state_reg.power};
      default: mapped = 1'b0;
    endcase
    if (!aligned) begin
      mapped = 1'b0;
      rd_val = 32'h0000_0000;
    end
  end

  assign wr_go = psel && penable && pwrite && mapped;

  // Output-state selection from the registered power and enable state.
  always_comb begin
    deepest = (pstate == SOSC_DEEPEST_STANDBY);
    idle12 = !deepest && (!state_reg.output_enable_ctrl ||
      pstate == SOSC_STANDBY1 || pstate == SOSC_STANDBY2);
    low_clk = deepest || (pstate == SOSC_STANDBY2);
  end

  always_comb begin
    state_next = state_reg;

    // Read data and error are captured in the setup phase and held for the access.
    if (psel && !penable) begin
      state_next.rdata = pwrite ? 32'h0000_0000 : rd_val;
      state_next.slverr = !mapped;
    end

    if (wr_go) begin
      case (idx)
        SOSC_IDX_POWER: begin
          state_next.power = pwdata[SOSC_POWER_LSB +: 2];
          state_next.clamp_en = pwdata[SOSC_CLAMP_BIT];
        end
        SOSC_IDX_OUTCTL: state_next.output_enable_ctrl = pwdata[0];
        SOSC_IDX_SYNCIDLE: state_next.sync_idle_level = pwdata[1:0];
        SOSC_IDX_CORERUN: state_next.timing_core_run = pwdata[0];
        SOSC_IDX_OSCEN: state_next.osc_en = pwdata[0];
        SOSC_IDX_POL12: state_next.pol12 = pwdata[24:0];
        SOSC_IDX_POL3: state_next.pol3 = pwdata[24:0];
        SOSC_IDX_GPOPOL: state_next.gpo_pol = pwdata[N_GPO-1:0];
        SOSC_IDX_GPODIR: state_next.gpo_dir = pwdata[N_GPO-1:0];
        default: state_next.rdata = state_reg.rdata;
      endcase
    end

    // Settling window after leaving the deepest standby; the status flag sets when it ends,
    // and the host model waits a fixed count before restarting the timing core.
    if (state_reg.settle_cnt != '0) begin
      state_next.settle_cnt = state_reg.settle_cnt - 1'b1;
      state_next.settled = (state_reg.settle_cnt == CNT_W'(1));
    end
    if (wr_go && idx == SOSC_IDX_POWER) begin
      if (pwdata[1:0] == 2'(SOSC_DEEPEST_STANDBY)) begin
        state_next.settle_cnt = '0;
        state_next.settled = 1'b0;
      end else if (deepest) begin
        state_next.settle_cnt = CNT_W'(SETTLE_CYC);
        state_next.settled = 1'b0;
      end
    end

    // Power gating of front end, core and oscillator.
    state_next.afe_on = (pstate == SOSC_NORMAL);
    state_next.ref_on = (pstate == SOSC_NORMAL) || (pstate == SOSC_STANDBY1);
    state_next.core_en = state_reg.timing_core_run && !low_clk;
    state_next.osc_on = state_reg.osc_en && !low_clk;
    state_next.xtal = low_clk ? 1'b0 : oscillator_run;

    // Vertical and substrate outputs.
    if (deepest) begin
      state_next.vout = state_reg.pol3[N_VERT-1:0];
      state_next.sub_out = state_reg.pol3[SOSC_SUB_BIT];
    end else if (idle12) begin
      state_next.vout = state_reg.pol12[N_VERT-1:0];
      state_next.sub_out = state_reg.pol12[SOSC_SUB_BIT];
    end else begin
      state_next.vout = vertical_run;
      state_next.sub_out = substrate_run;
    end

    // General outputs: idle level in any standby or disabled state, tristate
    // wherever the direction bit is clear.
    state_next.gout = (deepest || idle12) ? state_reg.gpo_pol : general_run;
    state_next.goe = state_reg.gpo_dir;

    // Horizontal and reset-gate drivers.
    // Disabled outputs alone keep full drive; only standby levels 1 and 2 lower it,
    // so a host that merely mutes the outputs does not slow the clock edges.
    state_next.h_oe = !deepest;
    state_next.drv_min = (pstate == SOSC_STANDBY1) || (pstate == SOSC_STANDBY2);
    if (deepest) begin
      state_next.h_odd = 1'b0;
      state_next.h_even = 1'b0;
      state_next.h_last = 1'b0;
      state_next.rg = 1'b0;
    end else if (idle12) begin
      state_next.h_odd = 1'b0;
      state_next.h_even = 1'b1;
      state_next.h_last = 1'b0;
      state_next.rg = 1'b0;
    end else begin
      state_next.h_odd = horizontal_odd_run;
      state_next.h_even = horizontal_even_run;
      state_next.h_last = last_horizontal_run;
      state_next.rg = reset_gate_run;
    end

    // Sync outputs and pixel clock; output-disable overrides standby 1 here.
    if (deepest) begin
      state_next.vsync = 1'b0;
      state_next.hsync = 1'b0;
    end else if (!state_reg.output_enable_ctrl || pstate == SOSC_STANDBY2) begin
      state_next.vsync = state_reg.sync_idle_level[0];
      state_next.hsync = state_reg.sync_idle_level[1];
    end else begin
      state_next.vsync = vertical_sync_run;
      state_next.hsync = horizontal_sync_run;
    end
    state_next.pix_clk = low_clk ? 1'b0 : pixel_clock_run;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.power <= SOSC_RST_POWER;
      state_reg.clamp_en <= SOSC_RST_CLAMP;
      state_reg.output_enable_ctrl <= SOSC_RST_OUTCTL;
      state_reg.timing_core_run <= SOSC_RST_CORERUN;
      state_reg.osc_en <= SOSC_RST_OSCEN;
      state_reg.sync_idle_level <= SOSC_RST_SYNCIDLE;
      state_reg.pol12 <= SOSC_RST_POL;
      state_reg.pol3 <= SOSC_RST_POL;
      state_reg.gpo_pol <= SOSC_RST_GPOPOL;
      state_reg.gpo_dir <= SOSC_RST_GPODIR;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign pslverr = state_reg.slverr;
  assign vertical_outs = state_reg.vout;
  assign substrate_clock_out = state_reg.sub_out;
  assign general_outs = state_reg.gout;
  assign general_outs_oe = state_reg.goe;
  assign horizontal_clock_odd = state_reg.h_odd;
  assign horizontal_clock_even = state_reg.h_even;
  assign last_horizontal_clock = state_reg.h_last;
  assign reset_gate_out = state_reg.rg;
  assign horizontal_oe = state_reg.h_oe;
  assign drive_minimum = state_reg.drv_min;
  assign vertical_sync = state_reg.vsync;
  assign horizontal_sync = state_reg.hsync;
  assign pixel_clock_out = state_reg.pix_clk;
  assign crystal_drive_out = state_reg.xtal;
  assign oscillator_enable = state_reg.osc_on;
  assign analog_front_end_on = state_reg.afe_on;
  assign reference_on = state_reg.ref_on;
  assign clamp_enable = state_reg.clamp_en;
  assign timing_core_enable = state_reg.core_en;

endmodule // sosc_standby_output_state_ctrl

// ===== sosc_ctrl_properties.sv
// Port-level checker for the standby and output-state controller.
// Assumes it is bound to the controller top and sees only its ports.
`timescale 1ns/100ps
module sosc_ctrl_properties
  import sosc_pkg::*;
#(
  parameter int N_VERT = 24,
  parameter int N_GPO = 8,
  parameter int PADDR_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic horizontal_oe,
  input wire logic drive_minimum,
  input wire logic horizontal_clock_odd,
  input wire logic horizontal_clock_even,
  input wire logic reset_gate_out,
  input wire logic vertical_sync,
  input wire logic pixel_clock_out,
  input wire logic crystal_drive_out,
  input wire logic timing_core_enable,
  input wire logic oscillator_enable,
  input wire logic analog_front_end_on,
  input wire logic reference_on,
  input wire logic [N_GPO-1:0] general_outs_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr_pow;
  logic [N_GPO-1:0] dir_wd;
  assign acc = psel && penable && pwrite;
  assign dir_wd = pwdata[N_GPO-1:0];
  assign wr_pow = acc && paddr == {SOSC_IDX_POWER, 2'b00};
  deep_quiet_a: assert property (!horizontal_oe |-> !vertical_sync && !pixel_clock_out
    && !crystal_drive_out && !timing_core_enable && !oscillator_enable && !analog_front_end_on)
    else $error("deepest standby left a clock or block running");
  idle_h_a: assert property (drive_minimum |-> horizontal_oe && !horizontal_clock_odd
    && horizontal_clock_even && !reset_gate_out) else $error("standby horizontal idle wrong");
  afe_normal_a: assert property (analog_front_end_on |-> reference_on && horizontal_oe
    && !drive_minimum) else $error("front end on outside normal state");
  enter_deep_a: assert property (wr_pow && pwdata[1:0] == 2'h3 |=> ##1 !horizontal_oe
    && !oscillator_enable) else $error("deepest standby not entered");
  leave_min_a: assert property (wr_pow && pwdata[1:0] == 2'h0 |=> ##1 horizontal_oe
    && !drive_minimum) else $error("normal state not entered");
  stby_drive_a: assert property (wr_pow && pwdata[1:0] inside {2'h1, 2'h2} |=> ##1
    drive_minimum) else $error("minimum drive missing in standby");
  core_stop_a: assert property (acc && paddr == {SOSC_IDX_CORERUN, 2'b00} && !pwdata[0]
    |=> ##1 !timing_core_enable) else $error("timing core kept running");
  dir_oe_a: assert property (acc && paddr == {SOSC_IDX_GPODIR, 2'b00} |=> ##1
    general_outs_oe == $past(dir_wd, 2)) else $error("general enables wrong");
  outctl_off_a: assert property (acc && paddr == {SOSC_IDX_OUTCTL, 2'b00} && !pwdata[0]
    |=> ##1 (!horizontal_oe || (horizontal_clock_even && !horizontal_clock_odd)))
    else $error("disabled outputs not idle");
endmodule // sosc_ctrl_properties

// ===== sosc_host_model.sv
// Host model: an APB master that programs the controller's registers.
// Assumes a rising-edge pclk; a wait for pready is bounded and fails the run.
`timescale 1ns/100ps
module sosc_host_model
  import sosc_pkg::*;
#(
  parameter int SETTLE = 20
) (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [9:0] paddr = 10'h000,
  output logic [31:0] pwdata = 32'h0000_0000
);
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 100);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!pready) begin
      tb.fail_count++;
      tb.test_done();
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, {i, 2'b00}, d, q, e);
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] q);
    logic e;
    xfer(1'b0, {i, 2'b00}, 32'h0000_0000, q, e);
  endtask
  // The crystal needs time to settle before the core may restart.
  task automatic exit_deepest();
    wr(SOSC_IDX_POWER, 32'h0000_0004);
    repeat (SETTLE) @(posedge pclk);
    wr(SOSC_IDX_CORERUN, 32'h0000_0000);
    wr(SOSC_IDX_CORERUN, 32'h0000_0001);
  endtask
endmodule // sosc_host_model

// ===== tb.sv
// Self-checking testbench for the standby and output-state controller.
// Assumes the host model and the checker files are compiled beside it.
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb;
  import sosc_pkg::*;
  localparam logic [40:0] RUN = 41'h0AA_AAAA_AAAB;
  int fail_count = 0;
  int num_checks = 0;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] vertical_run = 24'h00_0000;
  logic [23:0] vertical_outs;
  logic [7:0] general_run = 8'h00;
  logic [7:0] general_outs, general_outs_oe;
  logic substrate_run = 1'b0, horizontal_odd_run = 1'b0, horizontal_even_run = 1'b0;
  logic last_horizontal_run = 1'b0, reset_gate_run = 1'b0, vertical_sync_run = 1'b0;
  logic horizontal_sync_run = 1'b0, pixel_clock_run = 1'b0, oscillator_run = 1'b0;
  logic substrate_clock_out, horizontal_clock_odd, horizontal_clock_even, last_horizontal_clock;
  logic reset_gate_out, horizontal_oe, drive_minimum, vertical_sync, horizontal_sync;
  logic pixel_clock_out, crystal_drive_out, oscillator_enable, analog_front_end_on;
  logic reference_on, clamp_enable, timing_core_enable;
  sosc_standby_output_state_ctrl #(.SETTLE_CYC(20)) i_sosc_standby_output_state_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vertical_run(vertical_run), .substrate_run(substrate_run), .general_run(general_run),
    .horizontal_odd_run(horizontal_odd_run), .horizontal_even_run(horizontal_even_run),
    .last_horizontal_run(last_horizontal_run), .reset_gate_run(reset_gate_run),
    .vertical_sync_run(vertical_sync_run), .horizontal_sync_run(horizontal_sync_run),
    .pixel_clock_run(pixel_clock_run), .oscillator_run(oscillator_run),
    .vertical_outs(vertical_outs), .substrate_clock_out(substrate_clock_out),
    .general_outs(general_outs), .general_outs_oe(general_outs_oe),
    .horizontal_clock_odd(horizontal_clock_odd),
    .horizontal_clock_even(horizontal_clock_even),
    .last_horizontal_clock(last_horizontal_clock), .reset_gate_out(reset_gate_out),
    .horizontal_oe(horizontal_oe), .drive_minimum(drive_minimum),
    .vertical_sync(vertical_sync), .horizontal_sync(horizontal_sync),
    .pixel_clock_out(pixel_clock_out), .crystal_drive_out(crystal_drive_out),
    .oscillator_enable(oscillator_enable), .analog_front_end_on(analog_front_end_on),
    .reference_on(reference_on), .clamp_enable(clamp_enable),
    .timing_core_enable(timing_core_enable));
  sosc_host_model #(.SETTLE(20)) i_sosc_host_model (.pclk(pclk), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    i_sosc_host_model.wr(i, d);
    repeat (2) @(posedge pclk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset();
    logic [31:0] q;
    i_sosc_host_model.rd(SOSC_IDX_POWER, q);
    `CHK(q, 32'h0000_0003)
    `CHK(pready, 1'b1)
    `CHK({horizontal_oe, general_outs_oe, crystal_drive_out}, 10'h000)
    `CHK({substrate_clock_out, vertical_outs, general_outs}, 33'h0_0000_0000)
    $display("test reset done");
  endtask
  task automatic t_deep();
    wr(SOSC_IDX_POL3, 32'h00A5_5A5A);
    wr(SOSC_IDX_POL12, 32'h0100_0F0F);
    wr(SOSC_IDX_OUTCTL, 32'h0000_0000);
    `CHK(vertical_outs, 24'hA5_5A5A)
    `CHK({horizontal_oe, substrate_clock_out, pixel_clock_out}, 3'h0)
    $display("test deepest done");
  endtask
  task automatic t_stby();
    wr(SOSC_IDX_OUTCTL, 32'h0000_0001);
    wr(SOSC_IDX_GPOPOL, 32'h0000_00C3);
    wr(SOSC_IDX_SYNCIDLE, 32'h0000_0002);
    wr(SOSC_IDX_OSCEN, 32'h0000_0001);
    wr(SOSC_IDX_CORERUN, 32'h0000_0001);
    for (int s = 1; s < 3; s++) begin
      wr(SOSC_IDX_POWER, 32'(s));
      `CHK(drive_minimum, 1'b1)
      `CHK({horizontal_oe, horizontal_clock_odd, horizontal_clock_even, reset_gate_out}, 4'hA)
      `CHK(last_horizontal_clock, 1'b0)
      `CHK({substrate_clock_out, vertical_outs}, 25'h100_0F0F)
      `CHK(general_outs, 8'hC3)
      `CHK({crystal_drive_out, reference_on, vertical_sync, horizontal_sync, pixel_clock_out,
        timing_core_enable}, (s == 2) ? 6'h04 : 6'h3B)
    end
    $display("test standby done");
  endtask
  task automatic t_outctl();
    wr(SOSC_IDX_OUTCTL, 32'h0000_0000);
    wr(SOSC_IDX_POWER, 32'h0000_0000);
    `CHK({drive_minimum, horizontal_sync, pixel_clock_out}, 3'h3)
    `CHK(vertical_outs, 24'h00_0F0F)
    wr(SOSC_IDX_OUTCTL, 32'h0000_0001);
    `CHK({vertical_outs, horizontal_clock_odd}, RUN[40:16] | 25'h000_0001)
    `CHK({analog_front_end_on, reference_on, crystal_drive_out}, 3'h7)
    $display("test output enable done");
  endtask
  task automatic t_misc();
    logic [31:0] q;
    logic e;
    wr(SOSC_IDX_GPODIR, 32'h0000_005A);
    `CHK(general_outs_oe, 8'h5A)
    i_sosc_host_model.xfer(1'b0, 10'h3FC, 32'h0000_0000, q, e);
    `CHK({e, q}, 33'h1_0000_0000)
    wr(SOSC_IDX_POWER, 32'h0000_0003);
    `CHK({oscillator_enable, crystal_drive_out}, 2'h0)
    i_sosc_host_model.exit_deepest();
    repeat (2) @(posedge pclk);
    i_sosc_host_model.rd(SOSC_IDX_STATUS, q);
    `CHK(q[5], 1'b1)
    `CHK({timing_core_enable, oscillator_enable}, 2'h3)
    `CHK({clamp_enable, last_horizontal_clock, vertical_sync}, 3'h7)
    `CHK(general_outs, 8'hAA)
    $display("test misc done");
  endtask
  task automatic t_rst_mid();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    $display("test mid-run reset done");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    {vertical_run, substrate_run, general_run, horizontal_odd_run, horizontal_even_run,
     last_horizontal_run, reset_gate_run, vertical_sync_run, horizontal_sync_run,
     pixel_clock_run, oscillator_run} <= RUN;
    t_reset();
    t_deep();
    t_stby();
    t_outctl();
    t_misc();
    t_rst_mid();
    test_done();
  end
endmodule // tb
bind sosc_standby_output_state_ctrl sosc_ctrl_properties #(.N_VERT(N_VERT), .N_GPO(N_GPO),
  .PADDR_W(PADDR_W)) i_sosc_ctrl_properties (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .horizontal_oe(horizontal_oe), .drive_minimum(drive_minimum),
  .horizontal_clock_odd(horizontal_clock_odd), .horizontal_clock_even(horizontal_clock_even),
  .reset_gate_out(reset_gate_out), .vertical_sync(vertical_sync),
  .pixel_clock_out(pixel_clock_out), .crystal_drive_out(crystal_drive_out),
  .timing_core_enable(timing_core_enable), .oscillator_enable(oscillator_enable),
  .analog_front_end_on(analog_front_end_on), .reference_on(reference_on),
  .general_outs_oe(general_outs_oe));
